// ---- mps_defs.svh ----
// Purpose: constants for the mii phy source select block
// Assumes: apb slave, 32-bit data, one aligned word per register
// Notes: offsets are byte addresses
// Operation
// - receive fifos get 16KB minus transmit share
// - two-bit clock source field, bits six:five
// - decode 00/11 internal, 01 external, 10 off
// - clock field touches only rx/tx clocks
// - management select bit four, reset zero
// - select clear: management goes internal phy
// - select set: management goes external phy
// - management select independent of port enable
// - select set: internal mdio/mdc held low
// - select clear: external mdio tristate, mdc low
// - management select moves only mdio/mdc
// - tx size in 1KB units, 512B status
// - port enable bit enables external mii port
`ifndef MPS_DEFS_SVH
`define MPS_DEFS_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define MPS_CONF_ADDR 12'h074
`define MPS_RX_ALLOC_ADDR 12'h078
`define MPS_ADDR_W 12
// ----------------------------------------
// field positions
// ----------------------------------------
`define MPS_CLK_SEL_LO 5
`define MPS_CLK_SEL_HI 6
`define MPS_MGMT_SEL_BIT 4
`define MPS_EXT_EN_BIT 2
`define MPS_TX_SIZE_LO 16
`define MPS_TX_SIZE_HI 19
`define MPS_MUST_ONE_BIT 20
// ----------------------------------------
// reset values and sizes
// ----------------------------------------
`define MPS_CLK_SEL_RST 2'h0
`define MPS_TX_SIZE_RST 4'h5
`define MPS_TX_SIZE_MAX 4'he
`define MPS_RX_ALLOC_RST 5'h0b
`define MPS_TOTAL_KB 5'h10
`define MPS_TX_STATUS_BYTES 16'h0200
`endif

// ---- mps_pkg.sv ----
// Purpose: types for the mii phy source select block
// Assumes: nothing
// Notes: clock source decode values
package mps_pkg;
  // decoded clock source
  typedef enum logic [1:0] {
    MPS_SRC_INTERNAL,
    MPS_SRC_EXTERNAL,
    MPS_SRC_OFF
  } mps_src_type;
endpackage : mps_pkg

// ---- mps_clk_gate.sv ----
// Purpose: glitch-free enable of one link clock
// Assumes: enable is synchronous to clk_link after two flops
// Notes: latch-free gate, enable changes only while clock low
`timescale 1ns/1ps
module mps_clk_gate
  import mps_pkg::*;
(
  input wire logic clk_link,
  input wire logic sys_rst,
  input wire logic enable_async,
  output logic clk_out
);
  logic en_meta; // first sync stage
  logic en_sync; // second sync stage
  logic en_neg; // enable held over the low phase

  // ----------------------------------------
  // enable crossing
  // ----------------------------------------
  // two flops before anything looks at enable
  always_ff @(posedge clk_link) begin
    en_meta <= enable_async;
    en_sync <= en_meta;
  end

  // update on falling edge so high phase is never cut
  always_ff @(negedge clk_link) begin
    if (sys_rst) begin
      en_neg <= 1'b0;
    end else begin
      en_neg <= en_sync;
    end
  end

  assign clk_out = clk_link & en_neg;
endmodule : mps_clk_gate

// ---- mps_top.sv ----
// Purpose: hardware configuration register with mii clock and management routing
// Assumes: apb master obeys protocol; host stops tx/rx before writes
// Notes: link clocks gated in their own domain
`timescale 1ns/1ps
`include "mps_defs.svh"
module mps_top
  import mps_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic int_rx_clk,
  input wire logic int_tx_clk,
  input wire logic ext_rx_clk,
  input wire logic ext_tx_clk,
  output logic mac_rx_clk,
  output logic mac_tx_clk,
  input wire logic mac_mdc,
  input wire logic mac_mdio_out,
  input wire logic mac_mdio_oe,
  output logic mac_mdio_in,
  output logic int_mdc,
  output logic int_mdio_out,
  output logic int_mdio_oe,
  input wire logic int_mdio_in,
  output logic ext_mdc,
  output logic ext_mdio_out,
  output logic ext_mdio_oe,
  input wire logic ext_mdio_in,
  output logic external_port_enable,
  output logic [3:0] tx_alloc_kb,
  output logic [4:0] rx_alloc_kb
);
  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [1:0] mii_clock_source_field; // clock source code
  logic mgmt_port_target_bit; // management routing
  logic external_port_enable_bit; // external port enable
  logic [3:0] transmit_buffer_size_field; // tx share in kb
  logic must_be_one; // plain storage bit
  logic [31:0] cfg_word; // readback image
  logic hit_cfg; // address decode
  logic hit_rx; // rx share readback
  logic wr_en; // write strobe
  mps_src_type src; // decoded clock source
  logic sel_int; // internal clocks wanted
  logic sel_ext; // external clocks wanted
  logic mdio_in_meta; // first sync stage
  logic mdio_in_sync; // second sync stage

  assign hit_cfg = (paddr[11:0] == `MPS_CONF_ADDR);
  assign hit_rx = (paddr[11:0] == `MPS_RX_ALLOC_ADDR);
  assign wr_en = psel & penable & pwrite & hit_cfg;
  assign pready = 1'b1; // zero-wait answer
  assign pslverr = psel & penable & ~(hit_cfg | hit_rx);

  // ----------------------------------------
  // configuration writes
  // ----------------------------------------
  // no tx/rx interlock here: host stops them first
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mii_clock_source_field <= `MPS_CLK_SEL_RST;
      mgmt_port_target_bit <= 1'b0;
      external_port_enable_bit <= 1'b0;
      transmit_buffer_size_field <= `MPS_TX_SIZE_RST;
      must_be_one <= 1'b0;
    end else if (wr_en) begin
      mii_clock_source_field <= pwdata[`MPS_CLK_SEL_HI:`MPS_CLK_SEL_LO];
      mgmt_port_target_bit <= pwdata[`MPS_MGMT_SEL_BIT];
      external_port_enable_bit <= pwdata[`MPS_EXT_EN_BIT];
      // oversize request clamps to the largest share
      if (pwdata[`MPS_TX_SIZE_HI:`MPS_TX_SIZE_LO] > `MPS_TX_SIZE_MAX) begin
        transmit_buffer_size_field <= `MPS_TX_SIZE_MAX;
      end else begin
        transmit_buffer_size_field <= pwdata[`MPS_TX_SIZE_HI:`MPS_TX_SIZE_LO];
      end
      must_be_one <= pwdata[`MPS_MUST_ONE_BIT];
    end
  end

  always_comb begin
    cfg_word = 32'h0000_0000;
    cfg_word[`MPS_MUST_ONE_BIT] = must_be_one;
    cfg_word[`MPS_TX_SIZE_HI:`MPS_TX_SIZE_LO] = transmit_buffer_size_field;
    cfg_word[`MPS_CLK_SEL_HI:`MPS_CLK_SEL_LO] = mii_clock_source_field;
    cfg_word[`MPS_MGMT_SEL_BIT] = mgmt_port_target_bit;
    cfg_word[`MPS_EXT_EN_BIT] = external_port_enable_bit;
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      if (hit_cfg) begin
        prdata <= cfg_word;
      end else if (hit_rx) begin
        prdata <= {27'h0000000, rx_alloc_kb};
      end else begin
        prdata <= 32'h0000_0000; // unmapped reads zero
      end
    end
  end

  // ----------------------------------------
  // fifo shares and port enable
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_alloc_kb <= `MPS_TX_SIZE_RST;
      rx_alloc_kb <= `MPS_RX_ALLOC_RST;
      external_port_enable <= 1'b0;
    end else begin
      tx_alloc_kb <= transmit_buffer_size_field;
      rx_alloc_kb <= `MPS_TOTAL_KB - {1'b0, transmit_buffer_size_field};
      external_port_enable <= external_port_enable_bit;
    end
  end

  // ----------------------------------------
  // clock source decode
  // ----------------------------------------
  always_comb begin
    case (mii_clock_source_field)
      2'h0: src = MPS_SRC_INTERNAL;
      2'h1: src = MPS_SRC_EXTERNAL;
      2'h2: src = MPS_SRC_OFF;
      2'h3: src = MPS_SRC_INTERNAL;
      default: src = MPS_SRC_INTERNAL;
    endcase
  end
  assign sel_int = (src == MPS_SRC_INTERNAL);
  assign sel_ext = (src == MPS_SRC_EXTERNAL);

  // ----------------------------------------
  // link clock gating, one gate per link clock
  // ----------------------------------------
  // each gate syncs its enable into its own link clock; or-ing is safe
  // because selects change only while tx/rx are stopped
  logic g_irx, g_itx, g_erx, g_etx; // gated clocks
  mps_clk_gate u_irx (.clk_link(int_rx_clk), .sys_rst(sys_rst), .enable_async(sel_int), .clk_out(g_irx));
  mps_clk_gate u_itx (.clk_link(int_tx_clk), .sys_rst(sys_rst), .enable_async(sel_int), .clk_out(g_itx));
  mps_clk_gate u_erx (.clk_link(ext_rx_clk), .sys_rst(sys_rst), .enable_async(sel_ext), .clk_out(g_erx));
  mps_clk_gate u_etx (.clk_link(ext_tx_clk), .sys_rst(sys_rst), .enable_async(sel_ext), .clk_out(g_etx));
  // clock field steers only these two clocks
  assign mac_rx_clk = g_irx | g_erx;
  assign mac_tx_clk = g_itx | g_etx;

  // ----------------------------------------
  // management routing
  // ----------------------------------------
  // independent of the port enable bit
  always_comb begin
    if (mgmt_port_target_bit) begin
      int_mdc = 1'b0;
      int_mdio_out = 1'b0;
      int_mdio_oe = 1'b1;
      ext_mdc = mac_mdc;
      ext_mdio_out = mac_mdio_out;
      ext_mdio_oe = mac_mdio_oe;
    end else begin
      int_mdc = mac_mdc;
      int_mdio_out = mac_mdio_out;
      int_mdio_oe = mac_mdio_oe;
      ext_mdc = 1'b0;
      ext_mdio_out = 1'b0;
      ext_mdio_oe = 1'b0;
    end
  end

  // external pin passes two flops
  always_ff @(posedge clk) begin
    mdio_in_meta <= ext_mdio_in;
    mdio_in_sync <= mdio_in_meta;
  end
  assign mac_mdio_in = mgmt_port_target_bit ? mdio_in_sync : int_mdio_in;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_mgmt_int_low: assert property (@(posedge clk) disable iff (sys_rst)
    mgmt_port_target_bit |-> (!int_mdc && !int_mdio_out)) else $error("internal mgmt not low");
  chk_ext_tristate: assert property (@(posedge clk) disable iff (sys_rst)
    !mgmt_port_target_bit |-> (!ext_mdio_oe && !ext_mdc)) else $error("external mgmt not idle");
  chk_mgmt_int_route: assert property (@(posedge clk) disable iff (sys_rst)
    !mgmt_port_target_bit |-> (int_mdc == mac_mdc && mac_mdio_in == int_mdio_in)) else $error("int route");
  chk_mgmt_ext_route: assert property (@(posedge clk) disable iff (sys_rst)
    mgmt_port_target_bit |-> (ext_mdc == mac_mdc && ext_mdio_oe == mac_mdio_oe)) else $error("ext route");
  chk_clk_write_lands: assert property (@(posedge clk) disable iff (sys_rst)
    wr_en |=> mii_clock_source_field == $past(pwdata[6:5])) else $error("clock field not stored");
  chk_sel_write_lands: assert property (@(posedge clk) disable iff (sys_rst)
    wr_en |=> mgmt_port_target_bit == $past(pwdata[4])) else $error("select not stored");
  chk_clk_decode: assert property (@(posedge clk) disable iff (sys_rst)
    (mii_clock_source_field == 2'h3) |-> sel_int && !sel_ext) else $error("code 11 not internal");
  chk_clk_off: assert property (@(posedge clk) disable iff (sys_rst)
    (mii_clock_source_field == 2'h2) |-> !sel_int && !sel_ext) else $error("clocks not off");
  chk_rx_share: assert property (@(posedge clk) disable iff (sys_rst)
    $stable(transmit_buffer_size_field) |=> rx_alloc_kb + {1'b0, tx_alloc_kb} == 5'h10) else $error("rx share");
  chk_tx_limit: assert property (@(posedge clk) disable iff (sys_rst)
    transmit_buffer_size_field <= 4'he) else $error("tx size over limit");
  chk_port_enable: assert property (@(posedge clk) disable iff (sys_rst)
    wr_en |=> ##1 external_port_enable == $past(pwdata[2], 2)) else $error("port enable");
  cov_sel_ext: cover property (@(posedge clk) disable iff (sys_rst) wr_en && pwdata[4]);
  cov_clk_ext: cover property (@(posedge clk) disable iff (sys_rst) sel_ext);
  cov_clk_off: cover property (@(posedge clk) disable iff (sys_rst) src == MPS_SRC_OFF);
  cov_bad_addr: cover property (@(posedge clk) disable iff (sys_rst) pslverr);
endmodule : mps_top

// ---- mps_phy_model.sv ----
// Purpose: far-side phy model, mii clocks and management read data
// Assumes: mii clocks run free, 160 ns period
// Notes: edges sit off the system clock grid on purpose
`timescale 1ns/1ps
module mps_phy_model (
  output logic int_rx_clk,
  output logic int_tx_clk,
  output logic ext_rx_clk,
  output logic ext_tx_clk,
  output logic int_mdio_in,
  output logic ext_mdio_in
);
  // ----------------------------------------
  // clocks and answer streams
  // ----------------------------------------
  // four phases so a wrong mux choice shows up at once
  initial begin
    {int_rx_clk, int_tx_clk, ext_rx_clk, ext_tx_clk} = 4'h0;
    {int_mdio_in, ext_mdio_in} = 2'h3;
    #0.3;
    fork
      forever #80 int_rx_clk = ~int_rx_clk;
      #20 forever #80 int_tx_clk = ~int_tx_clk;
      #40 forever #80 ext_rx_clk = ~ext_rx_clk;
      #60 forever #80 ext_tx_clk = ~ext_tx_clk;
      // read data keeps changing, so a stale route cannot match
      #50.2 forever #100 int_mdio_in = ~int_mdio_in;
      forever #400 ext_mdio_in = ~ext_mdio_in;
    join
  end
endmodule : mps_phy_model

// ---- test_mii_phy_source_select.sv ----
// Purpose: self-checking bench for the mii source select block
// Assumes: zero-wait apb slave, read data held in access phase
// Notes: a monitor checks every transfer against a queue of notes
`timescale 1ns/1ps
module test_mii_phy_source_select import mps_pkg::*; ;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic mac_mdc = 0, mac_mdio_out = 0, mac_mdio_oe = 0;
  logic pready, pslverr, int_rx_clk, int_tx_clk, ext_rx_clk, ext_tx_clk, mac_rx_clk, mac_tx_clk;
  logic mac_mdio_in, int_mdc, int_mdio_out, int_mdio_oe, int_mdio_in, ext_mdc, ext_mdio_out;
  logic ext_mdio_oe, ext_mdio_in, external_port_enable;
  logic [3:0] tx_alloc_kb;
  logic [4:0] rx_alloc_kb;
  int fails = 0, total_checks = 0, seed = 48;
  logic [33:0] notes [$]; // {check data, expected error, data}
  always #4 clk = ~clk;
  mps_top dut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .int_rx_clk, .int_tx_clk, .ext_rx_clk, .ext_tx_clk, .mac_rx_clk, .mac_tx_clk,
    .mac_mdc, .mac_mdio_out, .mac_mdio_oe, .mac_mdio_in, .int_mdc, .int_mdio_out, .int_mdio_oe,
    .int_mdio_in, .ext_mdc, .ext_mdio_out, .ext_mdio_oe, .ext_mdio_in, .external_port_enable,
    .tx_alloc_kb, .rx_alloc_kb);
  mps_phy_model phy (.int_rx_clk, .int_tx_clk, .ext_rx_clk, .ext_tx_clk, .int_mdio_in, .ext_mdio_in);
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task complete_run;
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  // one apb transfer, request held until pready is seen
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [33:0] note);
    int n;
    notes.push_back(note);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      complete_run();
    end
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask : apb
  // monitor: each finished transfer takes the oldest note
  always @(posedge clk) begin : mon
    logic [33:0] e;
    if (psel && penable && pready === 1'b1) begin
      e = notes.pop_front();
      cmp({31'h0, pslverr}, {31'h0, e[32]});
      if (e[33]) cmp(prdata, e[31:0]);
    end
  end
  function automatic logic [31:0] cfg(logic [3:0] tx, logic [1:0] s, logic m, logic e);
    return {11'h0, 1'b1, tx, 9'h0, s, m, 1'b0, e, 2'h0};
  endfunction : cfg
  // mac clocks against the chosen source, or still when off
  task chk_clk(input logic [1:0] s);
    logic [1:0] x;
    for (int k = 0; k < 40; k++) begin
      @(posedge clk);
      #1;
      x = (s == 2'h1) ? {ext_rx_clk, ext_tx_clk} : (s == 2'h2) ? 2'h0 : {int_rx_clk, int_tx_clk};
      cmp({30'h0, mac_rx_clk, mac_tx_clk}, {30'h0, x});
    end
  endtask : chk_clk
  // management routing with random mac drive
  task chk_mgmt(input logic m);
    logic [2:0] r;
    logic last;
    int st;
    for (int k = 0; k < 8; k++) begin
      r = $random(seed);
      @(posedge clk);
      {mac_mdc, mac_mdio_out, mac_mdio_oe} <= r;
      @(posedge clk);
      #1;
      cmp({int_mdc, int_mdio_out, int_mdio_oe, ext_mdc, ext_mdio_oe, ext_mdio_out & m},
        m ? {3'b001, r[2], r[0], r[1]} : {r, 3'b000});
      if (!m) cmp({31'h0, mac_mdio_in}, {31'h0, int_mdio_in});
    end
    if (m) begin
      // external read data is synchronised, so wait for it to sit still
      st = 0;
      last = ext_mdio_in;
      for (int k = 0; k < 100 && st < 4; k++) begin
        @(posedge clk);
        #1;
        st = (ext_mdio_in === last) ? st + 1 : 0;
        last = ext_mdio_in;
      end
      if (st < 4) begin
        fails++;
        complete_run();
      end
      cmp({31'h0, mac_mdio_in}, {31'h0, ext_mdio_in});
    end
  endtask : chk_mgmt
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin : main
    logic [3:0] tx, txe;
    logic [1:0] s;
    logic m, e;
    repeat (3) @(posedge clk);
    sys_rst <= 0;
    apb(0, 32'h74, 32'h0, {2'b10, 32'h0005_0000});
    apb(0, 32'h78, 32'h0, {2'b10, 32'h0000_000b});
    for (int i = 0; i < 14; i++) begin
      tx = 4'hf - i[3:0];
      s = i[1:0];
      m = i[2];
      e = $random(seed);
      txe = (tx > 4'he) ? 4'he : tx;
      // mac is idle throughout, as the host must ensure
      apb(1, 32'h74, cfg(tx, s, m, e), 34'h0);
      apb(0, 32'h74, 32'h0, {2'b10, cfg(txe, s, m, e)});
      apb(0, 32'h78, 32'h0, {2'b10, 27'h0, 5'h10 - txe});
      cmp({27'h0, rx_alloc_kb}, 32'h10 - txe);
      cmp({28'h0, tx_alloc_kb}, {28'h0, txe});
      cmp({31'h0, external_port_enable}, {31'h0, e});
      repeat (80) @(posedge clk); // gate needs three link edges
      chk_clk(s);
      chk_mgmt(m);
    end
    apb(0, 32'h100, 32'h0, {2'b01, 32'h0});
    apb(1, 32'h100, 32'hffff_ffff, {2'b01, 32'h0});
    apb(0, 32'h74, 32'h0, {2'b10, cfg(txe, s, m, e)});
    complete_run();
  end
endmodule : test_mii_phy_source_select
